// ### design/srpc_pkg.sv
// Constants and carrier types for the system reset and power control block
package srpc_pkg;
    localparam logic [7:0] REG_GATE_OFS = 8'h00;
    localparam logic [7:0] REG_WDT_OFS = 8'h01;
    localparam logic [7:0] REG_STATUS_OFS = 8'h02;
    localparam int GATE_CONV_BIT = 0;
    localparam int GATE_SERIAL_BIT = 1;
    localparam int GATE_T8_BIT = 2;
    localparam int GATE_T16_BIT = 3;
    localparam int WDT_FLAG_BIT = 7;
    localparam int WDT_IRQEN_BIT = 6;
    localparam int WDT_P3_BIT = 5;
    localparam int WDT_CE_BIT = 4;
    localparam int WDT_EN_BIT = 3;
    localparam logic [3:0] GATE_RST = 4'h0;
    localparam logic [3:0] PRESCALE_RST = 4'h0;
    localparam logic [2:0] BOD_OFF_CODE = 3'h7;
    localparam int CORE_CLK_MHZ = 20;
    localparam int WDT_OSC_KHZ = 128;
    localparam int CE_WINDOW_CYC = 4;
    localparam int WDT_BASE_TICKS = 2048;
    localparam logic [3:0] WDT_LAST_SEL = 4'h9;
    localparam int STRETCH_BASE_US = 4;
    localparam int STRETCH_BASE_CYC = STRETCH_BASE_US * CORE_CLK_MHZ;
    localparam int STRETCH_W = 16;
    localparam int WDT_CNT_W = 20;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } srpc_bus_req_type;

    typedef struct packed {
        logic [3:0] gate;
        logic cmp_avail;
        logic core_reset;
        logic port_reset;
        logic stretching;
        logic [STRETCH_W-1:0] stretch_cnt;
        logic fetch_start;
        logic wdt_reset_pulse;
        logic wdt_en;
        logic wdt_irq_en;
        logic wdt_flag;
        logic wdt_ce;
        logic [2:0] ce_cnt;
        logic [3:0] prescale;
        logic [WDT_CNT_W-1:0] wdt_cnt;
        logic wdt_irq;
        logic ref_on;
        logic [7:0] rd_data;
    } srpc_state_type;
endpackage

// ### design/srpc_top.sv
// System reset, watchdog, reference enable and peripheral clock gating
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module srpc_top
    import srpc_pkg::*;
#(
    parameter int STRETCH_CYC = STRETCH_BASE_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire srpc_bus_req_type bus_req,
    output logic [7:0] rd_data,
    input wire logic por_low,
    input wire logic reset_pin_b,
    input wire logic pin_reset_enable,
    input wire logic bod_low,
    input wire logic [2:0] brownout_trigger_fuse,
    input wire logic [1:0] startup_time_fuse,
    input wire logic [3:0] clock_source_fuse,
    input wire logic watchdog_always_on_fuse,
    input wire logic wdt_osc_tick,
    input wire logic wdt_restart,
    input wire logic comparator_bandgap_select,
    input wire logic converter_enable,
    output logic timer16_clock_stop,
    output logic timer8_clock_stop,
    output logic serial_iface_clock_stop,
    output logic converter_clock_stop,
    output logic comparator_usable,
    output logic core_reset,
    output logic port_reset,
    output logic fetch_from_vector,
    output logic wdt_reset_pulse,
    output logic wdt_irq,
    output logic reference_on
);
    srpc_state_type q;
    srpc_state_type d;
    logic src_b;
    logic bod_enabled;
    logic wdt_en_eff;
    logic [STRETCH_W-1:0] target;
    logic [3:0] psel;
    logic [WDT_CNT_W-1:0] limit;
    logic gate_wr;
    logic wdt_wr;
    logic [3:0] wp;

    assign bod_enabled = brownout_trigger_fuse != BOD_OFF_CODE;
    // Level-sensitive sources act without a clock
    assign src_b = rst_b & ~por_low & ~(pin_reset_enable & ~reset_pin_b)
        & ~(bod_enabled & bod_low);
    assign wdt_en_eff = q.wdt_en | watchdog_always_on_fuse;
    assign target = STRETCH_W'(STRETCH_CYC)
        << ({1'b0, startup_time_fuse} + {2'b00, clock_source_fuse[0]});
    assign psel = (q.prescale > WDT_LAST_SEL) ? WDT_LAST_SEL : q.prescale;
    assign limit = (WDT_CNT_W'(WDT_BASE_TICKS) << psel) - WDT_CNT_W'(1);
    assign gate_wr = bus_req.wr && bus_req.addr == REG_GATE_OFS && !q.core_reset;
    assign wdt_wr = bus_req.wr && bus_req.addr == REG_WDT_OFS && !q.core_reset;
    assign wp = {bus_req.wdata[WDT_P3_BIT], bus_req.wdata[2:0]};

    always_comb begin
        d = q;
        d.fetch_start = 1'b0;
        d.wdt_reset_pulse = 1'b0;
        d.rd_data = 8'h00;
        // Reset stretch: starts on source release or after the watchdog pulse
        if (q.wdt_reset_pulse) begin
            d.stretching = 1'b1;
            d.stretch_cnt = '0;
        end else if (q.stretching) begin
            if (q.stretch_cnt == target - STRETCH_W'(1)) begin
                d.stretching = 1'b0;
                d.core_reset = 1'b0;
                d.fetch_start = 1'b1;
            end else begin
                d.stretch_cnt = q.stretch_cnt + STRETCH_W'(1);
            end
        end
        if (q.core_reset) begin
            // Registers stay at initial values while the core is held
            d.gate = GATE_RST;
            d.wdt_en = 1'b0;
            d.wdt_irq_en = 1'b0;
            d.wdt_flag = 1'b0;
            d.wdt_ce = 1'b0;
            d.ce_cnt = '0;
            d.prescale = PRESCALE_RST;
            d.wdt_cnt = '0;
        end else begin
            if (gate_wr) begin
                d.gate = bus_req.wdata[3:0];
            end
            if (q.wdt_ce) begin
                d.ce_cnt = q.ce_cnt + 3'd1;
                if (q.ce_cnt == 3'(CE_WINDOW_CYC - 1)) begin
                    d.wdt_ce = 1'b0;
                end
            end
            if (wdt_wr) begin
                d.wdt_irq_en = bus_req.wdata[WDT_IRQEN_BIT];
                if (bus_req.wdata[WDT_FLAG_BIT]) begin
                    d.wdt_flag = 1'b0;
                end
                if (bus_req.wdata[WDT_CE_BIT] && bus_req.wdata[WDT_EN_BIT]) begin
                    d.wdt_ce = 1'b1;
                    d.ce_cnt = '0;
                    d.wdt_en = 1'b1;
                    if (!watchdog_always_on_fuse) begin
                        d.prescale = wp;
                    end
                end else if (q.wdt_ce) begin
                    // Second step of the timed sequence
                    d.wdt_ce = 1'b0;
                    d.prescale = wp;
                    if (!watchdog_always_on_fuse) begin
                        d.wdt_en = bus_req.wdata[WDT_EN_BIT];
                    end
                end else begin
                    if (!watchdog_always_on_fuse) begin
                        d.prescale = wp;
                        d.wdt_en = q.wdt_en | bus_req.wdata[WDT_EN_BIT];
                    end
                end
            end
            if (wdt_restart || !(wdt_en_eff || q.wdt_irq_en)) begin
                d.wdt_cnt = '0;
            end else if (wdt_osc_tick) begin
                if (q.wdt_cnt == limit) begin
                    d.wdt_cnt = '0;
                    if (q.wdt_irq_en) begin
                        d.wdt_flag = 1'b1;
                        if (wdt_en_eff) begin
                            d.wdt_irq_en = 1'b0;
                        end
                    end else begin
                        d.wdt_reset_pulse = 1'b1;
                        d.core_reset = 1'b1;
                        d.stretching = 1'b0;
                        // Clear the leftover count so the delay starts from zero
                        d.stretch_cnt = '0;
                    end
                end else begin
                    d.wdt_cnt = q.wdt_cnt + WDT_CNT_W'(1);
                end
            end
        end
        d.port_reset = d.core_reset;
        d.cmp_avail = ~d.gate[GATE_CONV_BIT];
        d.wdt_irq = d.wdt_flag & d.wdt_irq_en;
        d.ref_on = bod_enabled | comparator_bandgap_select | converter_enable;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                REG_GATE_OFS: d.rd_data = {4'h0, q.gate};
                REG_WDT_OFS: d.rd_data = {q.wdt_flag, q.wdt_irq_en, q.prescale[3],
                    q.wdt_ce, wdt_en_eff, q.prescale[2:0]};
                REG_STATUS_OFS: d.rd_data = {5'h00, q.ref_on, q.stretching,
                    watchdog_always_on_fuse};
                default: d.rd_data = 8'h00;
            endcase
        end
    end

    // Any source clears state at once; counter restarts from zero
    always_ff @(posedge core_clk or negedge src_b) begin
        if (!src_b) begin
            q <= '0;
            q.core_reset <= 1'b1;
            q.port_reset <= 1'b1;
            q.stretching <= 1'b1;
            q.cmp_avail <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign rd_data = q.rd_data;
    assign timer16_clock_stop = q.gate[GATE_T16_BIT];
    assign timer8_clock_stop = q.gate[GATE_T8_BIT];
    assign serial_iface_clock_stop = q.gate[GATE_SERIAL_BIT];
    assign converter_clock_stop = q.gate[GATE_CONV_BIT];
    assign comparator_usable = q.cmp_avail;
    assign core_reset = q.core_reset;
    assign port_reset = q.port_reset;
    assign fetch_from_vector = q.fetch_start;
    assign wdt_reset_pulse = q.wdt_reset_pulse;
    assign wdt_irq = q.wdt_irq;
    assign reference_on = q.ref_on;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!src_b);

    chk_gate_reserved_zero: assert property (
        bus_req.rd && bus_req.addr == REG_GATE_OFS |=> rd_data[7:4] == 4'h0)
        else $error("reserved gate bits not zero");
    chk_t16_stop_write: assert property (
        gate_wr |=> timer16_clock_stop == $past(bus_req.wdata[GATE_T16_BIT]))
        else $error("timer16 stop not taken from write");
    chk_t8_stop_hold: assert property (
        !gate_wr && !q.core_reset |=> $stable(timer8_clock_stop))
        else $error("timer8 stop changed without write");
    chk_cmp_blocked: assert property (
        converter_clock_stop |-> !comparator_usable)
        else $error("comparator usable while converter stopped");
    chk_wdt_pulse_one: assert property (
        wdt_reset_pulse |=> !wdt_reset_pulse && core_reset && q.stretch_cnt == '0)
        else $error("watchdog pulse not one cycle");
    chk_stretch_len: assert property (
        fetch_from_vector |-> !core_reset && $past(q.stretch_cnt) == $past(target) - 1)
        else $error("stretch length wrong");
    chk_ce_window: assert property (
        $rose(q.wdt_ce) ##0 (!wdt_wr)[*4] |=> !q.wdt_ce)
        else $error("change enable not cleared after four cycles");
    chk_level2_on: assert property (
        watchdog_always_on_fuse && bus_req.rd && bus_req.addr == REG_WDT_OFS
        |=> rd_data[WDT_EN_BIT])
        else $error("watchdog not shown enabled at level two");
    chk_ref_cause: assert property (
        ##1 reference_on == $past(bod_enabled | comparator_bandgap_select | converter_enable))
        else $error("reference enable wrong");
    chk_port_follows: assert property (
        port_reset == core_reset)
        else $error("port reset differs from core reset");
    chk_irq_no_reset: assert property (
        q.wdt_irq_en && wdt_osc_tick && q.wdt_cnt == limit && !wdt_restart && !q.core_reset
        |=> !wdt_reset_pulse && q.wdt_flag)
        else $error("interrupt mode expiry wrong");
    chk_pulse_in_reset: assert property (
        wdt_reset_pulse |-> core_reset)
        else $error("watchdog pulse without internal reset");
    chk_fetch_single: assert property (
        fetch_from_vector |=> !fetch_from_vector)
        else $error("fetch start longer than one cycle");
    chk_regs_held: assert property (
        core_reset |=> q.gate == GATE_RST && q.wdt_cnt == '0 && !q.wdt_ce)
        else $error("registers not held at initial values in reset");
    chk_serial_stop: assert property (
        gate_wr |=> serial_iface_clock_stop == $past(bus_req.wdata[GATE_SERIAL_BIT]))
        else $error("serial stop not taken from write");
    chk_rd_idle: assert property (
        !bus_req.rd |=> rd_data == 8'h00)
        else $error("read data not zero without read");
    chk_restart_clears: assert property (
        wdt_restart && !q.core_reset |=> q.wdt_cnt == '0)
        else $error("restart did not clear watchdog counter");
    chk_wdt_stopped: assert property (
        !wdt_en_eff && !q.wdt_irq_en |=> q.wdt_cnt == '0)
        else $error("disabled watchdog counter not cleared");
    chk_tick_only: assert property (
        !wdt_osc_tick && !wdt_restart && !q.core_reset
        |=> q.wdt_cnt == $past(q.wdt_cnt) || q.wdt_cnt == '0)
        else $error("watchdog counter moved without oscillator tick");
    chk_lvl2_period_lock: assert property (
        watchdog_always_on_fuse && wdt_wr && !q.wdt_ce |=> $stable(q.prescale))
        else $error("period changed at level two without timed sequence");
    chk_lvl1_no_clear: assert property (
        !watchdog_always_on_fuse && wdt_wr && !q.wdt_ce && q.wdt_en |=> q.wdt_en)
        else $error("watchdog disabled without timed sequence");
    chk_ce_opens: assert property (
        wdt_wr && bus_req.wdata[WDT_CE_BIT] && bus_req.wdata[WDT_EN_BIT]
        |=> q.wdt_ce && q.ce_cnt == '0)
        else $error("change enable window not opened");

    cov_wdt_reset: cover property (wdt_reset_pulse ##1 core_reset);
    cov_wdt_irq: cover property ($rose(wdt_irq));
    cov_release: cover property ($fell(core_reset));
    cov_timed_seq: cover property ($rose(q.wdt_ce) ##[1:4] (wdt_wr && !bus_req.wdata[WDT_CE_BIT]));
    cov_lvl2_period: cover property (watchdog_always_on_fuse && $rose(q.prescale[0]));
endmodule // srpc_top
`default_nettype wire

// ### dv/srpc_periph_model.sv
// Peripheral-side model: two gated timers and the watchdog oscillator tick
`timescale 1ns/1ps
`default_nettype none
module srpc_periph_model (
    input wire logic core_clk,
    input wire logic core_reset,
    input wire logic timer16_clock_stop,
    input wire logic timer8_clock_stop,
    output logic wdt_osc_tick = 1'b0,
    output logic [15:0] t16_cnt,
    output logic [7:0] t8_cnt
);
    // Oscillator scaled down to one tick every other core cycle
    always @(posedge core_clk) begin
        wdt_osc_tick <= ~wdt_osc_tick;
        if (core_reset) begin
            t16_cnt <= 16'h0000;
            t8_cnt <= 8'h00;
        end else begin
            if (!timer16_clock_stop) t16_cnt <= t16_cnt + 16'h0001;
            if (!timer8_clock_stop) t8_cnt <= t8_cnt + 8'h01;
        end
    end
endmodule // srpc_periph_model
`default_nettype wire

// ### dv/srpc_top_tb.sv
// Self-checking bench for the reset, watchdog, reference and clock gating block
`timescale 1ns/1ps
`default_nettype none
module srpc_top_tb;
    import srpc_pkg::*;
    localparam int ST = 2;
    logic core_clk = 1'b0, rst_b = 1'b0, por_low = 1'b0, reset_pin_b = 1'b1;
    logic pin_reset_enable = 1'b1, bod_low = 1'b0, watchdog_always_on_fuse = 1'b0;
    logic wdt_restart = 1'b0, comparator_bandgap_select = 1'b0, converter_enable = 1'b0;
    logic [2:0] brownout_trigger_fuse = 3'h7;
    logic [1:0] startup_time_fuse = 2'h0;
    logic [3:0] clock_source_fuse = 4'h0;
    srpc_bus_req_type bus_req = '0;
    logic [7:0] rd_data, t8_cnt;
    logic [15:0] t16_cnt;
    logic wdt_osc_tick, timer16_clock_stop, timer8_clock_stop, serial_iface_clock_stop;
    logic converter_clock_stop, comparator_usable, core_reset, port_reset, fetch_from_vector;
    logic wdt_reset_pulse, wdt_irq, reference_on;
    int n_mismatch = 0;
    int n_tests = 0;

    srpc_top #(.STRETCH_CYC(ST)) dut (.core_clk, .rst_b, .bus_req, .rd_data, .por_low,
        .reset_pin_b, .pin_reset_enable, .bod_low, .brownout_trigger_fuse, .startup_time_fuse,
        .clock_source_fuse, .watchdog_always_on_fuse, .wdt_osc_tick, .wdt_restart,
        .comparator_bandgap_select, .converter_enable, .timer16_clock_stop, .timer8_clock_stop,
        .serial_iface_clock_stop, .converter_clock_stop, .comparator_usable, .core_reset,
        .port_reset, .fetch_from_vector, .wdt_reset_pulse, .wdt_irq, .reference_on);
    srpc_periph_model model (.core_clk, .core_reset, .timer16_clock_stop, .timer8_clock_stop,
        .wdt_osc_tick, .t16_cnt, .t8_cnt);

    always #25 core_clk = ~core_clk;

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic chk_rd(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1 chk(what, {8'h00, rd_data}, {8'h00, exp});
    endtask
    task automatic wait_evt(input bit irq, output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            #1 n++;
        end while ((irq ? wdt_irq : wdt_reset_pulse) !== 1'b1 && n < 9000);
    endtask
    // Counts edges until the internal reset falls, then checks the release
    task automatic after_reset(input int lo, input int slack);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            #1 n++;
        end while (core_reset === 1'b1 && n < 100);
        chk("stretch", 16'(n >= lo && n <= lo + slack), 16'h1);
        chk("fetch", 16'(fetch_from_vector), 16'h1);
        chk("ports", 16'(port_reset), 16'h0);
    endtask
    task automatic t_gate();
        logic [15:0] f16;
        logic [7:0] f8;
        bus_wr(REG_GATE_OFS, 8'hff);
        chk_rd("gate", REG_GATE_OFS, 8'h0f);
        chk("serial stop", 16'(serial_iface_clock_stop), 16'h1);
        chk("cmp usable", 16'({converter_clock_stop, comparator_usable}), 16'h2);
        f16 = t16_cnt;
        f8 = t8_cnt;
        repeat (5) @(posedge core_clk);
        #1 chk("t16 frozen", t16_cnt, f16);
        chk("t8 frozen", 16'(t8_cnt), 16'(f8));
        bus_wr(REG_GATE_OFS, 8'h00);
        repeat (3) @(posedge core_clk);
        #1 chk("t16 resumed", t16_cnt, f16 + 16'h0003);
        chk("t8 resumed", 16'(t8_cnt), 16'(f8 + 8'h03));
        chk("cmp back", 16'({serial_iface_clock_stop, comparator_usable}), 16'h1);
        chk_rd("unmapped", 8'h33, 8'h00);
    endtask
    // Sources: power-on, pin, brown-out, then brown-out and pin while disabled
    task automatic t_async();
        for (int k = 0; k < 5; k++) begin
            bus_wr(REG_GATE_OFS, 8'h05);
            #10 pin_reset_enable = (k != 4);
            brownout_trigger_fuse = (k == 3) ? 3'h7 : 3'h0;
            startup_time_fuse = (k == 0) ? 2'h0 : 2'h1;
            clock_source_fuse = 4'(k == 2);
            por_low = (k == 0);
            reset_pin_b = !(k == 1 || k == 4);
            bod_low = (k == 2 || k == 3);
            #1 chk("src", 16'({port_reset, core_reset}), k < 3 ? 16'h3 : 16'h0);
            #10 por_low = 1'b0;
            reset_pin_b = 1'b1;
            bod_low = 1'b0;
            if (k < 3) begin
                @(posedge core_clk);
                #10 por_low = 1'b1;
                #10 por_low = 1'b0;
                chk("restart", 16'(core_reset), 16'h1);
                after_reset(ST << k, 0);
            end
            chk_rd("gate kept", REG_GATE_OFS, k < 3 ? 8'h00 : 8'h05);
        end
        pin_reset_enable = 1'b1;
        brownout_trigger_fuse = 3'h7;
        startup_time_fuse = 2'h0;
        clock_source_fuse = 4'h0;
        bus_wr(REG_GATE_OFS, 8'h00);
    endtask
    task automatic t_ref();
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            brownout_trigger_fuse <= i[0] ? 3'h2 : 3'h7;
            comparator_bandgap_select <= i[1];
            converter_enable <= i[2];
            repeat (2) @(posedge core_clk);
            #1 chk("reference", 16'(reference_on), 16'(i != 0));
        end
    endtask
    task automatic t_timed();
        bus_wr(REG_WDT_OFS, 8'h18);
        chk_rd("wdt open", REG_WDT_OFS, 8'h18);
        repeat (4) @(posedge core_clk);
        chk_rd("wdt closed", REG_WDT_OFS, 8'h08);
        bus_wr(REG_WDT_OFS, 8'h00);
        chk_rd("wdt kept", REG_WDT_OFS, 8'h08);
        bus_wr(REG_WDT_OFS, 8'h18);
        bus_wr(REG_WDT_OFS, 8'h01);
        chk_rd("wdt off", REG_WDT_OFS, 8'h01);
        bus_wr(REG_WDT_OFS, 8'h00);
        chk_rd("wdt period", REG_WDT_OFS, 8'h00);
    endtask
    task automatic t_wdt();
        int n;
        bus_wr(REG_WDT_OFS, 8'h08);
        repeat (1000) @(posedge core_clk);
        wdt_restart <= 1'b1;
        @(posedge core_clk);
        wdt_restart <= 1'b0;
        wait_evt(1'b0, n);
        chk("wdt expiry", 16'(n >= 4088 && n <= 4104), 16'h1);
        chk("wdt reset", 16'(core_reset), 16'h1);
        @(posedge core_clk);
        #1 chk("pulse width", 16'(wdt_reset_pulse), 16'h0);
        after_reset(ST, 0);
        chk_rd("wdt cleared", REG_WDT_OFS, 8'h00);
        bus_wr(REG_WDT_OFS, 8'h40);
        wait_evt(1'b1, n);
        chk("irq expiry", 16'(n >= 4088 && n <= 4104), 16'h1);
        chk("irq no reset", 16'(core_reset), 16'h0);
        bus_wr(REG_WDT_OFS, 8'hc0);
        @(posedge core_clk);
        #1 chk("irq clear", 16'(wdt_irq), 16'h0);
        chk_rd("flag cleared", REG_WDT_OFS, 8'h40);
    endtask
    task automatic t_level2();
        watchdog_always_on_fuse = 1'b1;
        #10 rst_b = 1'b0;
        #10 chk("rst ports", 16'(port_reset), 16'h1);
        rst_b = 1'b1;
        after_reset(ST, 0);
        chk_rd("lvl2 en", REG_WDT_OFS, 8'h08);
        chk_rd("status", REG_STATUS_OFS, 8'h05);
        bus_wr(REG_WDT_OFS, 8'h01);
        chk_rd("lvl2 locked", REG_WDT_OFS, 8'h08);
        bus_wr(REG_WDT_OFS, 8'h18);
        bus_wr(REG_WDT_OFS, 8'h01);
        chk_rd("lvl2 period", REG_WDT_OFS, 8'h09);
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        after_reset(ST, 0);
        chk_rd("gate reset", REG_GATE_OFS, 8'h00);
        t_gate();
        t_async();
        t_ref();
        t_timed();
        t_wdt();
        t_level2();
        report_and_stop();
    end
    // Whole run needs about 9400 cycles
    initial begin
        #3_000_000;
        n_mismatch++;
        report_and_stop();
    end
endmodule // srpc_top_tb
`default_nettype wire
